// *** core/stp_top.sv ***
// Shared prescaler, clock select and capture routing for two timers
//
// Behaviour
// R1: select one ticks the timer every cycle
// R2: taps divide system clock by 8,64,256,1024
// R3: one free-running prescaler feeds both timers
// R4: first tap tick within 1 to N+1 cycles
// R5: count pin sampled through synchroniser flops
// R6: tick on rising (7) or falling (6) edge
// R7: pin edge updates counter 2.5-3.5 cycles later; code takes 2 to 3 cycles
// R8: change external selection only while pin stable
// R9: external clock below half system clock
// R10: external ticks bypass the prescaler divider
// R11: hold mode keeps prescaler reset, timers halted
// R12: clearing hold mode clears reset, timers start
// R13: reset request resets prescaler, self clears
// R14: choice bit routes second capture pin
// R15: select zero stops the timer
// R16: ticks are one-cycle count enables
//
// The implementer's own choices: the register addresses and register access over APB.
module stp_top
   import stp_pkg::*;
(
   input  wire logic                   pclk,               // System clock
   input  wire logic                   presetn,            // Async reset, active low
   input  wire logic                   psel,               // APB select
   input  wire logic                   penable,            // APB enable
   input  wire logic                   pwrite,             // APB direction
   input  wire logic [7:0]             paddr,              // APB byte address
   input  wire logic [31:0]            pwdata,             // APB write data
   output logic      [31:0]            prdata,             // APB read data
   output logic                        pready,             // APB ready
   output logic                        pslverr,            // APB error
   input  wire logic [STP_NTIMERS-1:0] external_count_pin, // Count pins, one per timer
   input  wire logic                   capture_pin_first,  // First capture pin
   input  wire logic                   capture_pin_second, // Second capture pin
   output logic      [STP_NTIMERS-1:0] timer_tick,         // Count enables, one cycle
   output logic                        timers_halted,      // Prescaler reset held
   output logic                        capture_to_second   // Routed capture for timer 1
);

   // ==========================================================
   // State
   typedef struct packed {
      stp_apb_ph_e      ph;
      logic [31:0]      rdata;
      logic             err;
      logic             timer_sync_hold;
      logic             capture_input_choice;
      logic             prescaler_reset_request;
      logic [2:0]       cs0;
      logic [2:0]       cs1;
      logic [9:0]       presc;
      logic [1:0]       cap_meta;
      logic [1:0]       cap_sync;
      logic             cap_out;
   } stp_state_s;

   stp_state_s  s_q;
   stp_state_s  s_d;
   stp_edge_s   ext_edge [STP_NTIMERS];
   logic [2:0]  cs_sel   [STP_NTIMERS];
   logic        setup;
   logic        wr_done;
   logic        wr_gc;
   logic        wr_cs;
   logic        mapped;

   assign cs_sel[0] = s_q.cs0;
   assign cs_sel[1] = s_q.cs1;

   // ==========================================================
   // APB decode
   assign setup   = psel & ~penable;
   assign wr_done = psel & penable & pready & pwrite;
   assign wr_gc   = wr_done & (paddr == STP_OFS_GEN_CTRL);
   assign wr_cs   = wr_done & (paddr == STP_OFS_CLK_SEL);
   assign mapped  = (paddr == STP_OFS_GEN_CTRL) | (paddr == STP_OFS_CLK_SEL) |
                    (paddr == STP_OFS_STATUS);

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;

      // Answer is prepared in setup so read data comes from a flop
      case (s_q.ph)
         STP_PH_IDLE: begin
            if (setup) begin
               s_d.ph    = STP_PH_ACCESS;
               s_d.err   = ~mapped;
               s_d.rdata = '0;
               if (!pwrite) begin
                  case (paddr)
                     STP_OFS_GEN_CTRL: begin
                        s_d.rdata[STP_GC_HOLD_BIT] = s_q.timer_sync_hold;
                        s_d.rdata[STP_GC_CAP_BIT]  = s_q.capture_input_choice;
                        s_d.rdata[STP_GC_RST_BIT]  = s_q.prescaler_reset_request;
                     end
                     STP_OFS_CLK_SEL: begin
                        s_d.rdata[STP_CS0_LSB +: STP_CS_W] = s_q.cs0;
                        s_d.rdata[STP_CS1_LSB +: STP_CS_W] = s_q.cs1;
                     end
                     STP_OFS_STATUS: begin
                        s_d.rdata[STP_ST_PRESC_LSB +: STP_PRESC_W] = s_q.presc;
                        s_d.rdata[STP_ST_RST_BIT] = s_q.prescaler_reset_request;
                     end
                     default: begin
                        s_d.rdata = '0;
                     end
                  endcase
               end
            end
         end
         STP_PH_ACCESS: begin
            s_d.ph  = STP_PH_IDLE;
            s_d.err = 1'b0;
         end
         default: begin
            s_d.ph = STP_PH_IDLE;
         end
      endcase

      // Hardware clears the request unless hold mode keeps it [R12] [R13]
      if (!s_q.timer_sync_hold) begin
         s_d.prescaler_reset_request = 1'b0;
      end
      // A software write wins over the hardware clear [R11]
      if (wr_gc) begin
         s_d.timer_sync_hold         = pwdata[STP_GC_HOLD_BIT];
         s_d.capture_input_choice    = pwdata[STP_GC_CAP_BIT];
         s_d.prescaler_reset_request = pwdata[STP_GC_RST_BIT];
      end
      if (wr_cs) begin
         s_d.cs0 = pwdata[STP_CS0_LSB +: STP_CS_W];
         s_d.cs1 = pwdata[STP_CS1_LSB +: STP_CS_W];
      end

      // Free-running, cleared only by the reset request [R3] [R13]
      if (s_q.prescaler_reset_request) begin
         s_d.presc = STP_PRESC_RESET;
      end else begin
         s_d.presc = s_q.presc + STP_PRESC_ONE;
      end

      // Capture pins synchronised, then routed [R14]
      s_d.cap_meta = {capture_pin_second, capture_pin_first};
      s_d.cap_sync = s_q.cap_meta;
      s_d.cap_out  = s_q.capture_input_choice ? s_q.cap_sync[1] : s_q.cap_sync[0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q                         <= '0;
         s_q.ph                      <= STP_PH_IDLE;
         s_q.timer_sync_hold         <= STP_GC_RESET[STP_GC_HOLD_BIT];
         s_q.capture_input_choice    <= STP_GC_RESET[STP_GC_CAP_BIT];
         s_q.prescaler_reset_request <= STP_GC_RESET[STP_GC_RST_BIT];
         s_q.cs0                     <= STP_CS_RESET;
         s_q.cs1                     <= STP_CS_RESET;
         s_q.presc                   <= STP_PRESC_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Per-timer clock select
   // A tap fires when the low prescaler bits are all ones, so two
   // timers on the same tap tick together and a reset moves both. [R3] [R4]
   generate
      for (genvar t = 0; t < STP_NTIMERS; t++) begin : g_sel
         logic tick;

         stp_ext_sync u_sync (
            .pclk    (pclk),
            .presetn (presetn),
            .pin     (external_count_pin[t]),
            .edge_o  (ext_edge[t]),
            .level_o ()
         );

         always_comb begin
            case (cs_sel[t])
               STP_CS_STOP:     tick = 1'b0;                                          // [R15]
               STP_CS_DIV1:     tick = 1'b1;                                          // [R1]
               STP_CS_DIV8:     tick = &(s_q.presc | ~STP_TAP8_MASK);                 // [R2]
               STP_CS_DIV64:    tick = &(s_q.presc | ~STP_TAP64_MASK);                // [R2]
               STP_CS_DIV256:   tick = &(s_q.presc | ~STP_TAP256_MASK);               // [R2]
               STP_CS_DIV1024:  tick = &(s_q.presc | ~STP_TAP1024_MASK);              // [R2]
               STP_CS_EXT_FALL: tick = ext_edge[t].fall;                              // [R6] [R10]
               STP_CS_EXT_RISE: tick = ext_edge[t].rise;                              // [R6] [R10]
               default:         tick = 1'b0;
            endcase
         end

         // Held reset halts every source, not only the taps [R11] [R16]
         assign timer_tick[t] = tick & ~s_q.prescaler_reset_request;
      end
   endgenerate

   // ==========================================================
   // Outputs
   assign prdata            = s_q.rdata;
   assign pready            = (s_q.ph == STP_PH_ACCESS);
   assign pslverr           = s_q.err & pready;
   assign timers_halted     = s_q.prescaler_reset_request;
   assign capture_to_second = s_q.cap_out;

   // ==========================================================
   // Checks
   a_div1_every: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      (s_q.cs0 == STP_CS_DIV1 && !s_q.prescaler_reset_request) |-> timer_tick[0])
      else $error("select one did not tick every cycle");

   a_tap8_phase: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (s_q.cs1 == STP_CS_DIV8 && !s_q.prescaler_reset_request) |->
      (timer_tick[1] == (s_q.presc[2:0] == 3'h7)))
      else $error("divide by eight tap at wrong phase");

   a_presc_free: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      !s_q.prescaler_reset_request |=> s_q.presc == $past(s_q.presc) + STP_PRESC_ONE)
      else $error("prescaler did not advance");

   a_first_tick: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      ($changed(s_q.cs0) && s_q.cs0 == STP_CS_DIV8) |->
      ##[0:8] (timer_tick[0] || s_q.prescaler_reset_request))
      else $error("first divide by eight tick too late");

   a_ext_rise: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (s_q.cs0 == STP_CS_EXT_RISE && !s_q.prescaler_reset_request) |->
      (timer_tick[0] == ext_edge[0].rise))
      else $error("rising edge tick mismatch");

   a_hold_keeps: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      (s_q.timer_sync_hold && s_q.prescaler_reset_request && !wr_gc) |=>
      (s_q.prescaler_reset_request && timer_tick == '0 && s_q.presc == STP_PRESC_RESET))
      else $error("hold mode lost the prescaler reset");

   a_rst_clears: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      (!s_q.timer_sync_hold && s_q.prescaler_reset_request && !wr_gc) |=>
      !s_q.prescaler_reset_request)
      else $error("reset request not cleared by hardware");

   a_rst_effect: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      (wr_gc && pwdata[STP_GC_RST_BIT]) |=> s_q.prescaler_reset_request ##1
      (s_q.presc == STP_PRESC_RESET))
      else $error("reset request did not clear prescaler");

   a_cap_route: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      $stable(s_q.capture_input_choice) |=> capture_to_second ==
      ($past(s_q.capture_input_choice) ? $past(s_q.cap_sync[1]) : $past(s_q.cap_sync[0])))
      else $error("capture routing wrong");

   a_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      (s_q.cs1 == STP_CS_STOP) |-> !timer_tick[1])
      else $error("stopped timer ticked");

   a_div1_second: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      (s_q.cs1 == STP_CS_DIV1 && !s_q.prescaler_reset_request) |-> timer_tick[1])
      else $error("select one on timer one did not tick");

   a_tap64_phase: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (s_q.cs0 == STP_CS_DIV64 && !s_q.prescaler_reset_request) |->
      (timer_tick[0] == (s_q.presc[5:0] == 6'h3f)))
      else $error("divide by sixty-four tap at wrong phase");

   a_tap256_phase: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (s_q.cs0 == STP_CS_DIV256 && !s_q.prescaler_reset_request) |->
      (timer_tick[0] == (s_q.presc[7:0] == 8'hff)))
      else $error("divide by two hundred fifty-six tap at wrong phase");

   a_tap1024_phase: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (s_q.cs1 == STP_CS_DIV1024 && !s_q.prescaler_reset_request) |->
      (timer_tick[1] == (s_q.presc == 10'h3ff)))
      else $error("divide by one thousand twenty-four tap at wrong phase");

   a_same_tap: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (s_q.cs0 == s_q.cs1 && s_q.cs0 != STP_CS_EXT_FALL && s_q.cs0 != STP_CS_EXT_RISE) |->
      (timer_tick[0] == timer_tick[1]))
      else $error("timers on one tap ticked apart");

   a_ext_fall: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (s_q.cs1 == STP_CS_EXT_FALL && !s_q.prescaler_reset_request) |->
      (timer_tick[1] == ext_edge[1].fall))
      else $error("falling edge tick mismatch");

   a_ext_direct: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      (s_q.cs0 == STP_CS_EXT_RISE && timer_tick[0]) |->
      ($past(external_count_pin[0], 2) && !$past(external_count_pin[0], 3)))
      else $error("external tick not traced to a pin edge");

   a_halt_gates: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      timers_halted |-> (timer_tick == '0))
      else $error("tick while timers halted");

   a_release_runs: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      (wr_gc && !pwdata[STP_GC_HOLD_BIT] && !pwdata[STP_GC_RST_BIT]) |=>
      (!timers_halted && !s_q.timer_sync_hold))
      else $error("release from hold left the timers halted");

   a_tick_single: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
      (timer_tick[0] && s_q.cs0 >= STP_CS_DIV8 && s_q.cs0 <= STP_CS_DIV1024) |=>
      (!timer_tick[0] || $changed(s_q.cs0)))
      else $error("tap tick wider than one cycle");

   a_stop_first: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      (s_q.cs0 == STP_CS_STOP) |-> !timer_tick[0])
      else $error("stopped timer zero ticked");

endmodule

// *** core/stp_pkg.sv ***
// Constants, types and register map of the shared timer prescaler
package stp_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0]  STP_OFS_GEN_CTRL = 8'h00;
   localparam logic [7:0]  STP_OFS_CLK_SEL  = 8'h04;
   localparam logic [7:0]  STP_OFS_STATUS   = 8'h08;

   // general_timer_control fields
   localparam int          STP_GC_HOLD_BIT  = 7;
   localparam int          STP_GC_CAP_BIT   = 6;
   localparam int          STP_GC_RST_BIT   = 0;
   localparam logic [7:0]  STP_GC_RESET     = 8'h00;

   // Clock select fields, one 3-bit field per timer
   localparam int          STP_CS_W         = 3;
   localparam int          STP_CS0_LSB      = 0;
   localparam int          STP_CS1_LSB      = 8;
   localparam logic [2:0]  STP_CS_RESET     = 3'h0;

   // Status fields
   localparam int          STP_ST_PRESC_LSB = 0;
   localparam int          STP_ST_RST_BIT   = 16;

   // ==========================================================
   // Clock source codes
   localparam logic [2:0]  STP_CS_STOP      = 3'h0;
   localparam logic [2:0]  STP_CS_DIV1      = 3'h1;
   localparam logic [2:0]  STP_CS_DIV8      = 3'h2;
   localparam logic [2:0]  STP_CS_DIV64     = 3'h3;
   localparam logic [2:0]  STP_CS_DIV256    = 3'h4;
   localparam logic [2:0]  STP_CS_DIV1024   = 3'h5;
   localparam logic [2:0]  STP_CS_EXT_FALL  = 3'h6;
   localparam logic [2:0]  STP_CS_EXT_RISE  = 3'h7;

   // ==========================================================
   // Prescaler
   localparam int          STP_PRESC_W      = 10;
   localparam logic [9:0]  STP_PRESC_RESET  = 10'h000;
   localparam logic [9:0]  STP_PRESC_ONE    = 10'h001;
   localparam logic [9:0]  STP_TAP8_MASK    = 10'h007;
   localparam logic [9:0]  STP_TAP64_MASK   = 10'h03f;
   localparam logic [9:0]  STP_TAP256_MASK  = 10'h0ff;
   localparam logic [9:0]  STP_TAP1024_MASK = 10'h3ff;
   localparam int          STP_NTIMERS      = 2;

   // ==========================================================
   // Types
   typedef enum logic [0:0] {
      STP_PH_IDLE   = 1'b0,
      STP_PH_ACCESS = 1'b1
   } stp_apb_ph_e;

   typedef struct packed {
      logic rise;
      logic fall;
   } stp_edge_s;

endpackage

// *** core/stp_ext_sync.sv ***
// Count pin synchroniser and edge detector for one timer
module stp_ext_sync
   import stp_pkg::*;
(
   input  wire logic      pclk,      // System clock
   input  wire logic      presetn,   // Async reset, active low
   input  wire logic      pin,       // Raw external count pin
   output stp_edge_s      edge_o,    // Edge strobes, one cycle
   output logic           level_o    // Synchronised pin level
);

   // ==========================================================
   // State
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } stp_sync_s;

   stp_sync_s s_q;
   stp_sync_s s_d;

   // Two flops before any logic; the latch half-cycle is absorbed here [R5]
   always_comb begin
      s_d      = s_q;
      s_d.meta = pin;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Edge detection on registered samples only
   assign edge_o.rise = s_q.sync & ~s_q.prev; // [R6]
   assign edge_o.fall = ~s_q.sync & s_q.prev; // [R6]
   assign level_o     = s_q.sync;

   a_edge_delay: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      edge_o.rise |-> $past(pin, 2) && !$past(pin, 3))
      else $error("rise strobe not two samples after pin edge");

endmodule

// *** tb/stp_timer_model.sv ***
// Behavioural pair of timer cores that count the selected ticks
module stp_timer_model
   import stp_pkg::*;
(
   input  wire logic                   pclk,       // System clock
   input  wire logic                   presetn,    // Async reset, active low
   input  wire logic [STP_NTIMERS-1:0] timer_tick, // Count enables
   output logic      [15:0]            cnt0,       // Timer 0 count
   output logic      [15:0]            cnt1        // Timer 1 count
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Counters
   // Ticks are enables in the pclk domain; a stretched tick shows as extra counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt0 <= 16'h0000;
         cnt1 <= 16'h0000;
      end else begin
         cnt0 <= cnt0 + {15'h0000, timer_tick[0]};
         cnt1 <= cnt1 + {15'h0000, timer_tick[1]};
      end
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the shared timer prescaler
module testbench
   import stp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, perr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, rnd;
   logic        pready, pslverr, halted, cap_first, cap_second, cap_out;
   logic [1:0]  pin, tick;
   logic [15:0] c0, c1, a0, a1;
   int          err_count, checks, seed, cyc, k, nr, nf;

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   stp_top stp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_count_pin(pin), .capture_pin_first(cap_first),
      .capture_pin_second(cap_second), .timer_tick(tick), .timers_halted(halted),
      .capture_to_second(cap_out));

   stp_timer_model stp_timer_model_i (.pclk(pclk), .presetn(presetn), .timer_tick(tick),
      .cnt0(c0), .cnt1(c1));

   // ==========================================================
   // Helpers
   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask

   // Request held until pready is seen high at a rising edge; answer taken at that edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic snap();
      @(negedge pclk);
      a0 = c0;
      a1 = c1;
   endtask

   function automatic int div_of(input logic [2:0] cs);
      case (cs)
         STP_CS_DIV8:   div_of = 8;
         STP_CS_DIV64:  div_of = 64;
         STP_CS_DIV256: div_of = 256;
         default:       div_of = 1024;
      endcase
   endfunction

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         complete_run();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      seed = 90;
      err_count = 0;
      checks = 0;
      cyc = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {pin, cap_first, cap_second} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, STP_OFS_GEN_CTRL, 32'h0);
      check(rd, {24'h0, STP_GC_RESET}, "gc reset");
      apb(1'b1, 8'h0c, 32'hffffffff);
      check(32'(perr), 32'h1, "unmapped");
      snap();
      repeat (50) @(negedge pclk);
      check(32'(c0 - a0), 32'h0, "stopped");
      // Divide by one on timer 0 only
      apb(1'b1, STP_OFS_CLK_SEL, 32'h0001);
      snap();
      repeat (100) @(negedge pclk);
      check(32'(c0 - a0), 32'd100, "div1");
      check(32'(c1 - a1), 32'h0, "t1 stop");
      // Every tap, the two timers on different taps; 2048 cycles hold whole periods
      for (k = 2; k <= 5; k++) begin
         apb(1'b1, STP_OFS_CLK_SEL, {21'h0, 3'(7 - k), 5'h0, 3'(k)});
         snap();
         repeat (2048) @(negedge pclk);
         check(32'(c0 - a0), 32'(2048 / div_of(3'(k))), "tap t0");
         check(32'(c1 - a1), 32'(2048 / div_of(3'(7 - k))), "tap t1");
      end
      // Prescaler reset from random phases, timer 0 on divide by 8
      apb(1'b1, STP_OFS_CLK_SEL, 32'h0002);
      for (k = 0; k < 3; k++) begin
         repeat (32'($random(seed)) & 32'h7) @(posedge pclk);
         apb(1'b1, STP_OFS_GEN_CTRL, 32'h01);
         snap();
         nr = 0;
         while (c0 == a0 && nr < 20) begin
            @(negedge pclk);
            nr++;
         end
         check(32'(nr >= 1 && nr <= 9), 32'h1, "first tick");
         apb(1'b0, STP_OFS_GEN_CTRL, 32'h0);
         check(rd, 32'h0, "req clear");
      end
      // Hold mode keeps both timers still, release starts them together
      apb(1'b1, STP_OFS_CLK_SEL, 32'h0101);
      apb(1'b1, STP_OFS_GEN_CTRL, 32'h81);
      snap();
      repeat (40) @(negedge pclk);
      check(32'(c0 - a0), 32'h0, "hold t0");
      check(32'(c1 - a1), 32'h0, "hold t1");
      check(32'(halted), 32'h1, "halted");
      apb(1'b0, STP_OFS_GEN_CTRL, 32'h0);
      check(rd, 32'h81, "hold read");
      apb(1'b0, STP_OFS_STATUS, 32'h0);
      check(rd, 32'h1 << STP_ST_RST_BIT, "status hold");
      apb(1'b1, STP_OFS_GEN_CTRL, 32'h00);
      repeat (30) @(negedge pclk);
      check(32'(c0 - a0), 32'(c1 - a1), "same start");
      check(32'((c0 - a0) >= 28 && (c0 - a0) <= 30), 32'h1, "run");
      check(32'(halted), 32'h0, "released");
      // External pins: selection changed while the pins are stable
      apb(1'b1, STP_OFS_CLK_SEL, 32'h0607);
      snap();
      // Pin launched just after an edge; the counter moves three edges later
      @(posedge pclk);
      pin <= 2'b11;
      nr = 0;
      while (c0 == a0 && nr < 10) begin
         @(negedge pclk);
         nr++;
      end
      check(32'(nr), 32'd4, "ext delay");
      nr = 1;
      nf = 0;
      for (k = 0; k < 40; k++) begin
         // Half periods of two to five cycles stay well below half the clock rate
         repeat (2 + (32'($random(seed)) & 32'h3)) @(posedge pclk);
         pin <= ~pin;
         if (pin[0]) nf++;
         else nr++;
      end
      repeat (6) @(negedge pclk);
      check(32'(c0 - a0), 32'(nr), "rises");
      check(32'(c1 - a1), 32'(nf), "falls");
      // Capture routing with random choices and pin levels
      for (k = 0; k < 8; k++) begin
         rnd = $random(seed);
         apb(1'b1, STP_OFS_GEN_CTRL, {25'h0, rnd[0], 6'h0});
         cap_first <= rnd[1];
         cap_second <= rnd[2];
         repeat (4) @(negedge pclk);
         check(32'(cap_out), 32'(rnd[0] ? rnd[2] : rnd[1]), "capture");
         apb(1'b0, STP_OFS_GEN_CTRL, 32'h0);
         check(rd, {25'h0, rnd[0], 6'h0}, "choice read");
      end
      complete_run();
   end
endmodule
